// ===== shared/jump_inc_defines.svh
// Purpose: constants for the jump and register-increment executor
// Assumes: 14-bit instruction words, 13-bit program counter
// Notes: opcode fields are compared against the top bits of the word
`ifndef JUMP_INC_DEFINES_SVH
`define JUMP_INC_DEFINES_SVH

// opcode and operand fields and their positions, and the page bits of the upper latch
`define JI_JUMP_OPC 3'h5
`define JI_JUMP_OPC_MSB 13
`define JI_JUMP_OPC_LSB 11
`define JI_INC_OPC 6'h0A
`define JI_INC_OPC_MSB 13
`define JI_INC_OPC_LSB 8
`define JI_LIT_MSB 10
`define JI_DEST_BIT 7
`define JI_ADDR_MSB 6
`define JI_LATCH_HI 4
`define JI_LATCH_LO 3

// reset values
`define JI_PC_RST 13'h0000
`define JI_DATA_RST 8'h00
`define JI_ADDR_RST 7'h00
`define JI_LIT_RST 11'h000
`define JI_HIGH_RST 2'h0

// timing: clock edges per instruction cycle
`define JI_PHASES 4

`endif

// ===== shared/jump_inc_pkg.sv
// Purpose: types shared by the jump and register-increment executor
// Assumes: nothing beyond the defines header
// Notes: carriers are packed structs
package jump_inc_pkg;

  // one instruction cycle is four phases, one clock each
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;

  // decoded operation held for the rest of the cycle
  typedef enum logic [1:0] {OP_NONE, OP_JUMP, OP_INC} op_t;

  // normal execute cycle or the dead second cycle of a jump
  typedef enum logic {CYC_EXEC, CYC_FLUSH} cyc_t;

  // data memory read request
  typedef struct packed {
    logic read;
    logic [6:0] addr;
  } mem_req_t;

  // result write-back to data memory, accumulator and zero flag
  typedef struct packed {
    logic ramWrite;
    logic accWrite;
    logic zeroWrite;
    logic zero;
    logic [7:0] value;
    logic [6:0] addr;
  } writeback_t;

  // program counter load
  typedef struct packed {
    logic load;
    logic [12:0] target;
  } pc_load_t;

endpackage : jump_inc_pkg

// ===== logic/phase_sequencer.sv
// Purpose: steps the four phases of each instruction cycle
// Assumes: one clock per phase, synchronous active-low reset
// Notes: phase comes from a flop and starts at the first phase
`include "jump_inc_defines.svh"

module phase_sequencer
  import jump_inc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  output phase_t phase
);

  // free-running phase ring, restarts at the first phase on reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase <= PH_Q1;
    end else begin
      case (phase)
        PH_Q1: phase <= PH_Q2;
        PH_Q2: phase <= PH_Q3;
        PH_Q3: phase <= PH_Q4;
        PH_Q4: phase <= PH_Q1;
        default: phase <= PH_Q1;
      endcase
    end
  end

endmodule : phase_sequencer

// ===== logic/jump_and_increment_exec.sv
// Purpose: decode and execute the unconditional jump and register increment
// Assumes: fetch holds instrWord steady through the first phase; data memory
//   answers a read within the phase in which memReq.read is high
// Notes: results leave as one-clock pulses after the fourth phase
`include "jump_inc_defines.svh"

module jump_and_increment_exec
  import jump_inc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [13:0] instrWord,
  input wire logic [7:0] upperLatch,
  input wire logic [7:0] readData,
  output phase_t phase,
  output mem_req_t memReq,
  output writeback_t writeBack,
  output pc_load_t pcLoad,
  output logic flushActive
);

  op_t opKind;
  cyc_t cycState;
  logic destReg;
  logic [10:0] literal;
  logic [1:0] targetHigh;
  logic [7:0] operand;
  logic [7:0] result;
  logic decodeNow;
  logic isJump;
  logic isInc;

  phase_sequencer u_phase (
    .clk(clk),
    .reset_n(reset_n),
    .phase(phase)
  );

  // decode only in a live cycle; the word fetched behind a jump is dropped
  assign decodeNow = (phase == PH_Q1) && (cycState == CYC_EXEC);
  assign isJump = instrWord[`JI_JUMP_OPC_MSB:`JI_JUMP_OPC_LSB] == `JI_JUMP_OPC;
  assign isInc = instrWord[`JI_INC_OPC_MSB:`JI_INC_OPC_LSB] == `JI_INC_OPC;

  // first phase: decode and hold the operand fields
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      opKind <= OP_NONE;
      destReg <= 1'b0;
      literal <= `JI_LIT_RST;
    end else if (decodeNow) begin
      if (isJump) begin
        opKind <= OP_JUMP;
      end else if (isInc) begin
        opKind <= OP_INC;
      end else begin
        opKind <= OP_NONE;
      end
      destReg <= instrWord[`JI_DEST_BIT];
      literal <= instrWord[`JI_LIT_MSB:0];
    end else if (phase == PH_Q1) begin
      opKind <= OP_NONE; // dead cycle: nothing executes
    end
  end

  // read request to data memory, raised for the second phase only
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      memReq <= '0;
    end else if (decodeNow && isInc) begin
      memReq.read <= 1'b1;
      memReq.addr <= instrWord[`JI_ADDR_MSB:0];
    end else begin
      memReq.read <= 1'b0;
    end
  end

  // second phase: take the register value or the page bits
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      operand <= `JI_DATA_RST;
      targetHigh <= `JI_HIGH_RST;
    end else if (phase == PH_Q2) begin
      operand <= readData;
      targetHigh <= upperLatch[`JI_LATCH_HI:`JI_LATCH_LO];
    end
  end

  // third phase: process; the 8-bit sum wraps on its own
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      result <= `JI_DATA_RST;
    end else if (phase == PH_Q3) begin
      result <= operand + 8'h01;
    end
  end

  // fourth phase: write to the chosen destination, one clock wide
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      writeBack <= '0;
    end else if (phase == PH_Q4 && opKind == OP_INC) begin
      writeBack.ramWrite <= destReg;
      writeBack.accWrite <= !destReg;
      writeBack.zeroWrite <= 1'b1;
      writeBack.zero <= (result == 8'h00);
      writeBack.value <= result;
      writeBack.addr <= memReq.addr;
    end else begin
      writeBack.ramWrite <= 1'b0;
      writeBack.accWrite <= 1'b0;
      writeBack.zeroWrite <= 1'b0; // jump leaves every flag alone
    end
  end

  // fourth phase of a jump: load the counter
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pcLoad <= '{load: 1'b0, target: `JI_PC_RST};
    end else if (phase == PH_Q4 && opKind == OP_JUMP) begin
      pcLoad.load <= 1'b1;
      pcLoad.target <= {targetHigh, literal};
    end else begin
      pcLoad.load <= 1'b0;
    end
  end

  // a jump costs a second cycle in which every phase is idle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cycState <= CYC_EXEC;
    end else if (phase == PH_Q4) begin
      case (cycState)
        CYC_EXEC: cycState <= (opKind == OP_JUMP) ? CYC_FLUSH : CYC_EXEC;
        CYC_FLUSH: cycState <= CYC_EXEC;
        default: cycState <= CYC_EXEC;
      endcase
    end
  end

  // tells fetch to discard its word while the dead cycle runs
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flushActive <= 1'b0;
    end else if (phase == PH_Q4) begin
      flushActive <= (cycState == CYC_EXEC) && (opKind == OP_JUMP);
    end
  end

  // jump decoded: counter load appears four edges later
  property p_jump_decode;
    @(posedge clk) disable iff (!reset_n)
      (decodeNow && isJump) |-> ##4 pcLoad.load;
  endproperty
  a_jump_decode: assert property (p_jump_decode) else $error("jump not loaded");

  property p_jump_low;
    @(posedge clk) disable iff (!reset_n)
      (decodeNow && isJump) |-> ##4 (pcLoad.target[10:0] == $past(instrWord[10:0], 4));
  endproperty
  a_jump_low: assert property (p_jump_low) else $error("jump literal wrong");

  property p_jump_high;
    @(posedge clk) disable iff (!reset_n)
      (decodeNow && isJump) |-> ##4 (pcLoad.target[12:11] == $past(upperLatch[4:3], 3));
  endproperty
  a_jump_high: assert property (p_jump_high) else $error("jump page bits wrong");

  // second cycle of a jump does nothing and no flag moves
  property p_jump_idle;
    @(posedge clk) disable iff (!reset_n)
      (decodeNow && isJump) |-> ##4 (!writeBack.zeroWrite && flushActive)
        ##1 (!pcLoad.load && !writeBack.zeroWrite && !writeBack.ramWrite
        && !writeBack.accWrite && !memReq.read)[*4];
  endproperty
  a_jump_idle: assert property (p_jump_idle) else $error("jump second cycle busy");

  property p_inc_read;
    @(posedge clk) disable iff (!reset_n)
      (decodeNow && isInc) |=> (memReq.read && memReq.addr == $past(instrWord[6:0]));
  endproperty
  a_inc_read: assert property (p_inc_read) else $error("increment read missing");

  property p_inc_value;
    @(posedge clk) disable iff (!reset_n)
      (decodeNow && isInc) |-> ##4 (writeBack.value == 8'($past(readData, 3) + 8'h01));
  endproperty
  a_inc_value: assert property (p_inc_value) else $error("increment value wrong");

  property p_inc_acc;
    @(posedge clk) disable iff (!reset_n)
      (decodeNow && isInc && !instrWord[7]) |-> ##4 (writeBack.accWrite && !writeBack.ramWrite);
  endproperty
  a_inc_acc: assert property (p_inc_acc) else $error("accumulator not written");

  property p_inc_reg;
    @(posedge clk) disable iff (!reset_n)
      (decodeNow && isInc && instrWord[7]) |-> ##4 (writeBack.ramWrite && !writeBack.accWrite
        && writeBack.addr == $past(instrWord[6:0], 4));
  endproperty
  a_inc_reg: assert property (p_inc_reg) else $error("register not written back");

  property p_inc_zero;
    @(posedge clk) disable iff (!reset_n)
      (writeBack.ramWrite || writeBack.accWrite) |->
        (writeBack.zeroWrite && writeBack.zero == (writeBack.value == 8'h00));
  endproperty
  a_inc_zero: assert property (p_inc_zero) else $error("zero flag wrong");

  property p_inc_single;
    @(posedge clk) disable iff (!reset_n)
      (decodeNow && isInc) |-> ##4 (writeBack.zeroWrite && decodeNow)
        ##1 (!writeBack.zeroWrite)[*3];
  endproperty
  a_inc_single: assert property (p_inc_single) else $error("increment not one cycle");

  c_jump: cover property (@(posedge clk) disable iff (!reset_n) pcLoad.load);
  c_inc_acc: cover property (@(posedge clk) disable iff (!reset_n) writeBack.accWrite);
  c_inc_wrap: cover property (@(posedge clk) disable iff (!reset_n)
    writeBack.ramWrite && writeBack.zero);

endmodule : jump_and_increment_exec

// ===== bench/data_memory_model.sv
// Purpose: data memory on the far side of the executor
// Assumes: read data is answered in the same clock as the read request
// Notes: outside a read the data lines show the inverse of the last answer
module data_memory_model
  import jump_inc_pkg::*;
(
  input wire logic clk,
  input mem_req_t memReq,
  input writeback_t writeBack,
  output logic [7:0] readData
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [0:127];
  logic [7:0] lastData = 8'h00;

  // undriven lines must not keep a stale value the design could lean on
  always_comb begin
    readData = memReq.read ? mem[memReq.addr] : ~lastData;
  end

  // remember the answer, accept write-back into the addressed register
  always @(posedge clk) begin
    if (memReq.read) begin
      lastData <= readData;
    end
    if (writeBack.ramWrite) begin
      mem[writeBack.addr] <= writeBack.value;
    end
  end
endmodule : data_memory_model

// ===== bench/jump_and_increment_exec_test.sv
// Purpose: self-checking bench for the jump and increment executor
// Assumes: one clock per phase, words offered at the falling edge in Q1
// Notes: 14'h3FFF is an idle word that the block ignores
module jump_and_increment_exec_test
  import jump_inc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [13:0] instrWord = 14'h3FFF;
  logic [7:0] upperLatch = 8'h00;
  logic [7:0] readData;
  phase_t phase;
  mem_req_t memReq;
  writeback_t writeBack;
  pc_load_t pcLoad;
  logic flushActive;
  int fails = 0;
  int n_compared = 0;

  always #5 clk = ~clk;

  jump_and_increment_exec u_dut (.clk(clk), .reset_n(reset_n), .instrWord(instrWord),
    .upperLatch(upperLatch), .readData(readData), .phase(phase), .memReq(memReq),
    .writeBack(writeBack), .pcLoad(pcLoad), .flushActive(flushActive));

  data_memory_model u_mem (.clk(clk), .memReq(memReq), .writeBack(writeBack),
    .readData(readData));

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check_vec(input logic [12:0] got, input logic [12:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_vec

  task automatic check_bit(input logic got, input logic exp);
    check_vec(13'(got), 13'(exp));
  endtask : check_bit

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  // offer a word in Q1, leave at the falling edge of the read phase
  task automatic issue(input logic [13:0] w);
    int k;
    k = 0;
    while (phase !== PH_Q1 && k < 8) begin
      @(negedge clk);
      k++;
    end
    instrWord = w;
    step(1);
    instrWord = 14'h3FFF;
  endtask : issue

  task automatic inc_case(input logic d, input logic [6:0] f, input logic [7:0] init);
    logic [7:0] exp;
    exp = init + 8'h01;
    u_mem.mem[f] = init;
    issue({6'h0A, d, f});
    check_bit(memReq.read, 1'b1);
    check_vec(13'(memReq.addr), 13'(f));
    step(3);
    check_bit(writeBack.ramWrite, d);
    check_bit(writeBack.accWrite, !d);
    check_vec(13'(writeBack.value), 13'(exp));
    check_bit(writeBack.zeroWrite, 1'b1);
    check_bit(writeBack.zero, exp == 8'h00);
    check_vec(13'(writeBack.addr), 13'(f));
    check_vec(13'(phase), 13'(PH_Q1));
    step(1);
    check_bit(writeBack.ramWrite | writeBack.accWrite, 1'b0);
    check_vec(13'(u_mem.mem[f]), 13'(d ? exp : init));
  endtask : inc_case

  // latch changes after its sampling phase; only the sampled bits may count
  task automatic jump_case(input logic [10:0] lit, input logic [7:0] latch);
    upperLatch = latch;
    issue({3'h5, lit});
    step(1);
    upperLatch = ~latch;
    step(2);
    check_bit(pcLoad.load, 1'b1);
    check_vec(pcLoad.target, {latch[4:3], lit});
    check_bit(writeBack.zeroWrite, 1'b0);
    check_bit(flushActive, 1'b1);
    instrWord = {6'h0A, 1'b1, 7'h01};
    step(1);
    instrWord = 14'h3FFF;
    check_bit(memReq.read | pcLoad.load, 1'b0);
    step(2);
    check_bit(flushActive, 1'b1);
    step(1);
    check_bit(flushActive, 1'b0);
    check_vec(13'(phase), 13'(PH_Q1));
  endtask : jump_case

  // near-miss opcodes must leave the read request, write-back strobes and counter load quiet
  task automatic other_case(input logic [13:0] w);
    issue(w);
    check_bit(memReq.read, 1'b0);
    step(3);
    check_bit(writeBack.ramWrite | writeBack.accWrite | writeBack.zeroWrite, 1'b0);
    check_bit(pcLoad.load, 1'b0);
  endtask : other_case

  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    check_bit(pcLoad.load | writeBack.ramWrite | memReq.read, 1'b0);
    check_vec(13'(phase), 13'(PH_Q1));
    reset_n = 1'b1;
    inc_case(1'b1, 7'h05, 8'hFF);
    inc_case(1'b0, 7'h7F, 8'h7F);
    inc_case(1'b0, 7'h00, 8'hFF);
    inc_case(1'b1, 7'h40, 8'h80);
    jump_case(11'h7FF, 8'h18);
    jump_case(11'h000, 8'hE7);
    jump_case(11'h555, 8'h08);
    other_case(14'h0B05);
    other_case(14'h2000);
    other_case(14'h0E85);
    inc_case(1'b1, 7'h05, 8'h00);
    tally_and_finish();
  end

  // the whole run needs well under a thousand clocks
  initial begin
    #50000;
    fails++;
    tally_and_finish();
  end
endmodule : jump_and_increment_exec_test
